// ---- hdl/fwsr_pkg.sv ----
package fwsr_pkg;
   localparam int AW            = 20;
   localparam int DW            = 8;
   localparam int BIT_POLL      = 7;
   localparam int BIT_TOG1      = 6;
   localparam int BIT_LIMIT     = 5;
   localparam int BIT_ETIMER    = 3;
   localparam int BIT_TOG2      = 2;
   localparam int T_CLK_NS      = 10;
   localparam int T_STROBE_NS   = 70;
   localparam int STROBE_CYC    = (T_STROBE_NS + T_CLK_NS - 1) / T_CLK_NS;
   localparam int T_SEP_US      = 50;
   localparam int SEP_CYC       = T_SEP_US * 1000 / T_CLK_NS;
   localparam logic [AW-1:0] RESET_ADDR = 20'h00000;
   localparam logic [DW-1:0] RESET_CMD  = 8'hF0;

   typedef enum logic [1:0] {
      FWSR_PEND,
      FWSR_DONE,
      FWSR_FAIL
   } fwsr_result_t;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
      logic          wr;
   } fwsr_req_t;
endpackage

// ---- hdl/fwsr_host.sv ----
`timescale 1ns/1ns
// Flash rules behind this block
// R1 - Start status check with two back-to-back full bus reads, compare toggle bit.
// R2 - Device stops toggling when done; array data valid on next read.
// R3 - Still toggling: check limit flag; if high re-check toggle; toggling means failure.
// R4 - Toggling with limit low: keep polling, restarting from first read pair.
// R5 - Device raises the timing-limit flag when pulse count limit is exceeded.
// R6 - Programming one over zero halts; limit flag later reads one.
// R7 - After a timing-limit failure the host writes the reset command.
// R8 - Erase timer flag low during acceptance window, high after; new erase restarts.
// R9 - Acceptance window applies only to sector erase, not chip erase.
// R10 - Timer flag may be ignored only if erase commands stay under 50 us apart.
// R11 - After sector erase, confirm acceptance via polling or toggle bit, then timer flag; this host checks toggle bit one and never reads the timer flag.
// R12 - Timer flag high: only erase suspend accepted; low: more sector erases accepted.
// R13 - Read timer flag before and after each further sector erase command.
// R14 - Suspended sector reads: poll 1, toggle one still, limit 0, toggle two toggling.
// R15 - Outside suspended sector reads return array data, ready high.
// R16 - Status reads that use poll bit or toggle two carry a valid target address.
// R17 - Programming shows complement of bit 7 on poll bit, then true value.
// R18 - Toggle bit one inverts on every read during program or erase.
// R19 - Ready/busy low while busy, released high when ready, suspended or standby.
// R20 - Toggle bit two toggles on reads inside sectors selected for erase.
// R21 - Busy device drives status instead of array data, updated each read.
module fwsr_host
   import fwsr_pkg::*;
(
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          sys_rst,
   // User command: start checking an operation at a target address
   input  wire logic          start,
   input  wire logic [AW-1:0] target_addr,
   output logic               busy,
   output logic               result_valid,
   output fwsr_result_t       result,
   output logic [DW-1:0]      array_data,
   // Flash pins
   output logic [AW-1:0]      flash_addr,
   output logic               flash_ce_n,
   output logic               flash_oe_n,
   output logic               flash_we_n,
   input  wire logic [DW-1:0] flash_dq_in,
   output logic [DW-1:0]      flash_dq_out,
   output logic               flash_dq_oe,
   input  wire logic          ready_busy_out
);
   typedef enum logic [2:0] {
      S_IDLE, S_RD1, S_RD2, S_RECHK1, S_RECHK2, S_DATA, S_RESET, S_END
   } fwsr_state_t;

   fwsr_state_t   state;
   fwsr_req_t     req;
   logic [7:0]    strobe_cnt;
   logic          first_tog;
   logic [DW-1:0] sample;
   logic          strobe_done;
   logic          sample_edge;
   logic          toggling;

   // Strobes stay low for the whole access time, then rise for one cycle to close it
   assign strobe_done = (strobe_cnt == 8'(STROBE_CYC));
   assign sample_edge = (strobe_cnt == 8'(STROBE_CYC - 1));
   assign toggling    = sample[BIT_TOG1] != first_tog;
   assign busy        = (state != S_IDLE);

   // Each bus cycle holds its strobe for the access time, sampled on the last edge
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         strobe_cnt <= 8'h00;
      end else if (state == S_IDLE || state == S_END || strobe_done) begin
         strobe_cnt <= 8'h00;
      end else begin
         strobe_cnt <= strobe_cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         req <= '0;
      end else if (state == S_IDLE && start) begin
         req <= '{addr: target_addr, data: 8'h00, wr: 1'b0}; // R16
      end else if (state == S_RESET || (state == S_RECHK2 && strobe_done && toggling)) begin
         // Reset is the only command written: no further erase is ever issued
         req <= '{addr: RESET_ADDR, data: RESET_CMD, wr: 1'b1}; // R7 R10 R13
      end else if (state == S_END) begin
         req <= '0;
      end
   end

   // Sample the full bus on every read; DQ change mid-cycle is absorbed by the strobe time
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sample <= 8'h00;
      end else if (sample_edge && !req.wr) begin
         // Taken while the strobes are still low; a released bus carries nothing
         sample <= flash_dq_in;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         first_tog  <= 1'b0;
      end else if (state == S_RD2 && strobe_cnt == 8'h00) begin
         first_tog  <= sample[BIT_TOG1]; // R1
      end else if (state == S_RECHK2 && strobe_cnt == 8'h00) begin
         first_tog  <= sample[BIT_TOG1]; // R3
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= S_IDLE;
      end else begin
         unique case (state)
            S_IDLE:   if (start) state <= S_RD1; // R11
            S_RD1:    if (strobe_done) state <= S_RD2; // R1
            S_RD2: begin
               if (strobe_done) begin
                  if (!toggling) state <= S_DATA; // R2
                  else if (sample[BIT_LIMIT]) state <= S_RECHK1; // R3
                  else state <= S_RD1; // R4
               end
            end
            S_RECHK1: if (strobe_done) state <= S_RECHK2; // R3
            S_RECHK2: begin
               if (strobe_done) begin
                  if (toggling) state <= S_RESET; // R7
                  else state <= S_DATA;
               end
            end
            S_DATA:   if (strobe_done) state <= S_END; // R2
            S_RESET:  if (strobe_done) state <= S_END; // R7
            S_END:    state <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         result_valid <= 1'b0;
         result       <= FWSR_PEND;
         array_data   <= 8'h00;
      end else begin
         result_valid <= (state == S_END);
         if (state == S_DATA && strobe_done) begin
            result     <= FWSR_DONE;
            array_data <= sample;
         end else if (state == S_RESET) begin
            result     <= FWSR_FAIL; // R7
         end else if (state == S_IDLE && start) begin
            result     <= FWSR_PEND;
         end
      end
   end

   // Strobes high between cycles so every read is a distinct cycle for the toggle bits
   always_comb begin
      flash_addr   = req.addr;
      flash_dq_out = req.data;
      flash_dq_oe  = req.wr && (state == S_RESET);
      flash_ce_n   = !(busy && state != S_END && !strobe_done);
      flash_oe_n   = !(busy && state != S_END && !strobe_done && !req.wr);
      flash_we_n   = !(flash_dq_oe && !strobe_done);
   end

   // Assertions
   property p_two_reads;
      @(posedge mclk) disable iff (sys_rst)
         (state == S_RD1 && strobe_done) |=> state == S_RD2 && !flash_oe_n;
   endproperty
   a_two_reads: assert property (p_two_reads) else $error("no read pair"); // R1

   property p_reset_after_fail;
      @(posedge mclk) disable iff (sys_rst)
         (state == S_RECHK2 && strobe_done && toggling) |=> state == S_RESET;
   endproperty
   a_reset_after_fail: assert property (p_reset_after_fail) else $error("no reset cmd"); // R7

   property p_limit_recheck;
      @(posedge mclk) disable iff (sys_rst)
         (state == S_RD2 && strobe_done && sample[BIT_TOG1] != first_tog
          && sample[BIT_LIMIT]) |=> state == S_RECHK1;
   endproperty
   a_limit_recheck: assert property (p_limit_recheck) else $error("no recheck"); // R3

   property p_restart;
      @(posedge mclk) disable iff (sys_rst)
         (state == S_RD2 && strobe_done && sample[BIT_TOG1] != first_tog
          && !sample[BIT_LIMIT]) |=> state == S_RD1;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart"); // R4

   property p_addr_valid;
      @(posedge mclk) disable iff (sys_rst)
         (!flash_oe_n) |-> flash_addr == $past(flash_addr) || $past(state) == S_IDLE;
   endproperty
   a_addr_valid: assert property (p_addr_valid) else $error("address moved"); // R16

   property p_done_data;
      @(posedge mclk) disable iff (sys_rst)
         (state == S_RD2 && strobe_done && sample[BIT_TOG1] == first_tog)
         |=> state == S_DATA ##[1:20] result_valid && result == FWSR_DONE;
   endproperty
   a_done_data: assert property (p_done_data) else $error("no data read"); // R2

   property p_write_data;
      @(posedge mclk) disable iff (sys_rst)
         (!flash_we_n) |-> flash_dq_oe && flash_dq_out == RESET_CMD;
   endproperty
   a_write_data: assert property (p_write_data) else $error("bad write"); // R7

   property p_fail_result;
      @(posedge mclk) disable iff (sys_rst)
         (state == S_RESET && strobe_done) |=> ##1 result_valid && result == FWSR_FAIL;
   endproperty
   a_fail_result: assert property (p_fail_result) else $error("fail not reported"); // R7

   c_done:  cover property (@(posedge mclk) result_valid && result == FWSR_DONE);
   c_fail:  cover property (@(posedge mclk) result_valid && result == FWSR_FAIL);
   c_again: cover property (@(posedge mclk) state == S_RD2 ##1 state == S_RD1);
   c_recheck: cover property (@(posedge mclk) state == S_RECHK2 ##1 state == S_DATA);
endmodule

// ---- dv/fwsr_flash_model.sv ----
`timescale 1ns/1ns
module fwsr_flash_model
   import fwsr_pkg::*;
(
   // Host pins
   input  wire logic [AW-1:0] flash_addr,
   input  wire logic          flash_oe_n,
   input  wire logic          flash_we_n,
   input  wire logic [DW-1:0] flash_dq_out,
   input  wire logic          flash_ce_n,
   // Scenario set-up
   input  wire logic          arm,
   input  wire logic [7:0]    busy_reads,
   input  wire logic [7:0]    limit_at,
   input  wire logic [DW-1:0] array_byte,
   // Device side and observations
   output logic [DW-1:0]      flash_dq_in,
   output logic               ready_busy_out,
   output logic [AW-1:0]      last_wr_addr,
   output logic [DW-1:0]      last_wr_data,
   output logic [AW-1:0]      last_rd_addr,
   output logic [7:0]         wr_cnt
);
   logic [7:0]    rd_cnt;
   logic          tog;
   logic          aborted;
   logic          active;
   logic          limit;
   logic [DW-1:0] last_out;
   logic [DW-1:0] drive_val;
   assign active = !aborted && rd_cnt < busy_reads;
   // A nonzero limit_at stands for a one-over-zero program that halts and runs out of time
   assign limit = limit_at != 8'h00 && rd_cnt >= limit_at;
   assign ready_busy_out = active ? 1'b0 : 1'b1;
   // Erase timer reads as already expired; toggle two follows toggle one
   assign drive_val = active ? {~array_byte[7], tog, limit, array_byte[4], 1'b1, tog,
                                array_byte[1:0]} : array_byte;
   // Released bus shows the inverse of the last byte, so stale data never matches
   always_comb begin
      if (!flash_ce_n && !flash_oe_n)
         flash_dq_in = drive_val;
      else
         flash_dq_in = ~last_out;
   end
   always @(posedge flash_oe_n or posedge arm) begin
      if (arm) begin
         rd_cnt <= 8'h00;
         tog <= 1'b0;
      end else begin
         last_out <= drive_val;
         last_rd_addr <= flash_addr;
         rd_cnt <= rd_cnt + 8'h01;
         tog <= active ? ~tog : tog;
      end
   end
   // Any write aborts the operation, as the reset command does
   always @(posedge flash_we_n or posedge arm) begin
      if (arm) begin
         aborted <= 1'b0;
         wr_cnt <= 8'h00;
      end else begin
         last_wr_addr <= flash_addr;
         last_wr_data <= flash_dq_out;
         wr_cnt <= wr_cnt + 8'h01;
         aborted <= 1'b1;
      end
   end
endmodule

// ---- dv/tb_fwsr_host.sv ----
`timescale 1ns/1ns
module tb_fwsr_host;
   import fwsr_pkg::*;
   logic          mclk, sys_rst, start, busy, result_valid, arm;
   logic          flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, ready_busy_out;
   logic [AW-1:0] target_addr, flash_addr, last_wr_addr, last_rd_addr;
   logic [DW-1:0] array_data, flash_dq_in, flash_dq_out, last_wr_data;
   logic [7:0]    busy_reads, limit_at, wr_cnt;
   fwsr_result_t  result;
   int            mismatches = 0;
   int            check_count = 0;
   fwsr_host uut (.mclk(mclk), .sys_rst(sys_rst), .start(start), .target_addr(target_addr),
      .busy(busy), .result_valid(result_valid), .result(result), .array_data(array_data),
      .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
      .flash_dq_oe(flash_dq_oe), .ready_busy_out(ready_busy_out));
   fwsr_flash_model flash (.flash_addr(flash_addr), .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n),
      .arm(arm), .busy_reads(busy_reads), .limit_at(limit_at), .array_byte(8'h1A),
      .flash_dq_in(flash_dq_in), .ready_busy_out(ready_busy_out), .last_wr_addr(last_wr_addr),
      .last_wr_data(last_wr_data), .last_rd_addr(last_rd_addr), .wr_cnt(wr_cnt));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_res(input fwsr_result_t got, input fwsr_result_t exp);
      cmp_val({30'h0, got}, {30'h0, exp});
   endtask
   // Arms the device, starts one check and waits for its final verdict
   task automatic run(input logic [7:0] br, input logic [7:0] la, input logic [AW-1:0] ta);
      int n;
      @(negedge mclk);
      busy_reads = br;
      limit_at = la;
      target_addr = ta;
      arm = 1'b1;
      @(negedge mclk);
      arm = 1'b0;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      cmp_val({31'h0, busy}, 32'h1);
      n = 0;
      while (!(result_valid === 1'b1 && result !== FWSR_PEND) && n < 3000) begin
         @(posedge mclk);
         #1 n++;
      end
      if (n >= 3000) begin
         mismatches++;
         stop_test();
      end
   endtask
   task automatic sc_quick();
      run(8'h00, 8'h00, 20'h12345);
      cmp_res(result, FWSR_DONE);
      cmp_val({24'h0, array_data}, 32'h1A);
      cmp_val({12'h0, last_rd_addr}, 32'h12345);
      cmp_val({31'h0, busy}, 32'h0);
   endtask
   task automatic sc_restart();
      run(8'h04, 8'h00, 20'hABCDE);
      cmp_res(result, FWSR_DONE);
      cmp_val({24'h0, array_data}, 32'h1A);
   endtask
   task automatic sc_fail();
      run(8'hC8, 8'h01, 20'h00F00);
      cmp_res(result, FWSR_FAIL);
      cmp_val({24'h0, wr_cnt}, 32'h1);
      cmp_val({12'h0, last_wr_addr}, {12'h0, RESET_ADDR});
      cmp_val({24'h0, last_wr_data}, {24'h0, RESET_CMD});
   endtask
   task automatic sc_recheck();
      run(8'h02, 8'h01, 20'h7FFFF);
      cmp_res(result, FWSR_DONE);
      cmp_val({24'h0, wr_cnt}, 32'h0);
   endtask
   initial begin
      sys_rst = 1'b1;
      start = 1'b0;
      arm = 1'b0;
      target_addr = '0;
      busy_reads = 8'h00;
      limit_at = 8'h00;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      sc_quick();
      sc_restart();
      sc_fail();
      sc_recheck();
      stop_test();
   end
endmodule
